// [rtl/standby_mode_controller.sv]
// standby mode controller: halt and stop entry, release and peripheral parking
//
// Behaviour
// - halt instruction enters halt from either clock
// - unmasked interrupt releases halt; service or next
// - halt release to service waits 8-9 clocks
// - halt release to next instruction waits 2-3 clocks
// - non-maskable interrupt always releases halt, services
// - unmasked test input releases halt, next instruction
// - reset in halt gives normal reset processing
// - mask, priority, enable, in-service decide release outcome
// - stop entered only from main system clock
// - crystal output pulled up during stop
// - pending interrupt turns stop into halt, then stabilize
// - stop halts main oscillator, CPU; ports hold
// - 16-bit timer runs only on subsystem watch clock
// - 8-bit timers run only on external clock pins
// - watch timer runs only with subsystem clock selected
// - real-time port needs external trigger or timer pin
// - serial needs external clock; auto and UART stop
// - bus lines parked: hi-z, hold, strobe levels
// - stop released by interrupt, test input, reset only
// - interrupt stop release waits stabilization, then service/next
// - test input stop release waits stabilization, next instruction
// - reset in stop waits stabilization before reset processing
module standby_mode_controller
    import standby_pkg::*;
#(
    parameter int STAB_BASE = STAB_BASE_LOG2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic haltExec,
    input wire logic stopExec,
    input wire logic cpuOnSubsystemClock,
    input wire logic maskIrqRequest,
    input wire logic interrupt_mask_flag,
    input wire logic priority_select_flag,
    input wire logic interrupt_acknowledge_enable,
    input wire logic in_service_priority_flag,
    input wire logic nmiRequest,
    input wire logic testInput,
    input wire logic testMaskFlag,
    input wire logic resetRequest,
    input wire logic [2:0] stabilization_time_select,
    input wire logic subsystemClockPresent,
    input wire logic watchTimerOnSubsystemClock,
    input wire logic timer0OnWatchOutput,
    input wire logic timer1ExtClockSel,
    input wire logic timer2ExtClockSel,
    input wire logic timer5ExtClockSel,
    input wire logic timer6ExtClockSel,
    input wire logic realTimeExtTrigger,
    input wire logic serialExtClock,
    input wire logic serialAutoOrUart,
    input wire logic [7:0] busAddrDataOut,
    input wire logic [15:0] busAddrIn,
    input wire logic busAddrStrobeIn,
    input wire logic busReadIn,
    input wire logic busWriteIn,
    input wire logic busWaitOe,
    output logic cpuClockEnable,
    output logic mainOscEnable,
    output logic resumeNext,
    output logic startService,
    output logic startReset,
    output logic standbyHalt,
    output logic standbyStop,
    output logic crystalPullUp,
    output logic portLatchHold,
    output logic timer16RunEn,
    output logic timer12RunEn,
    output logic timer56RunEn,
    output logic watchTimerRunEn,
    output logic realTimePortRunEn,
    output logic serialRunEn,
    output logic [7:0] muxed_addr_data_lines_o,
    output logic muxed_addr_data_lines_oe,
    output logic [15:0] high_addr_lines,
    output logic addr_latch_strobe,
    output logic readStrobe,
    output logic writeStrobe,
    output logic waitPinOe
);
    // ------------------------------------------------------------------
    // release decoding
    // ------------------------------------------------------------------
    logic irqRelease;
    logic irqService;
    logic testRelease;
    logic anyStopRelease;

    always_comb begin
        irqRelease = maskIrqRequest && !interrupt_mask_flag;
        irqService = interrupt_acknowledge_enable &&
            (!priority_select_flag || in_service_priority_flag);
        testRelease = testInput && !testMaskFlag;
        anyStopRelease = irqRelease || testRelease || resetRequest;
    end

    // ------------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------------
    standby_state_e state_r, state_nxt;
    exit_kind_e exitKind_r, exitKind_nxt;
    logic [STAB_CNT_W-1:0] stabCnt_r, stabCnt_nxt;
    logic [3:0] wakeCnt_r, wakeCnt_nxt;
    logic [2:0] stabSel;

    function automatic logic [STAB_CNT_W-1:0] stabLoad(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel > STAB_SEL_MAX) ? STAB_SEL_MAX : sel;
        // clamp the select so long waits still fit the counter width
        stabLoad = STAB_CNT_W'((32'h1 << (STAB_BASE + 32'(s))) - 32'h1);
    endfunction

    always_comb begin
        stabSel = stabilization_time_select;
        state_nxt = state_r;
        exitKind_nxt = exitKind_r;
        stabCnt_nxt = stabCnt_r;
        wakeCnt_nxt = wakeCnt_r;
        case (state_r)
            ST_RUN: begin
                if (stopExec && !cpuOnSubsystemClock) begin
                    if (irqRelease) begin
                        // pending request: stop collapses to a halt and waits out
                        // the stabilization time before operating again
                        state_nxt = ST_STAB;
                        exitKind_nxt = irqService ? EXIT_SERVICE : EXIT_NEXT;
                        stabCnt_nxt = stabLoad(stabSel);
                    end else begin
                        state_nxt = ST_STOP;
                    end
                end else if (haltExec) begin
                    state_nxt = ST_HALT;
                end
            end
            ST_HALT: begin
                // reset first, then nmi, then maskable, then test input
                if (resetRequest) begin
                    state_nxt = ST_WAKE;
                    exitKind_nxt = EXIT_RESET;
                    wakeCnt_nxt = 4'h0;
                end else if (nmiRequest) begin
                    state_nxt = ST_WAKE;
                    exitKind_nxt = EXIT_SERVICE;
                    wakeCnt_nxt = WAIT_VECTORED - 4'h1;
                end else if (irqRelease) begin
                    state_nxt = ST_WAKE;
                    exitKind_nxt = irqService ? EXIT_SERVICE : EXIT_NEXT;
                    wakeCnt_nxt = irqService ? WAIT_VECTORED - 4'h1
                                             : WAIT_NEXT - 4'h1;
                end else if (testRelease) begin
                    state_nxt = ST_WAKE;
                    exitKind_nxt = EXIT_NEXT;
                    wakeCnt_nxt = WAIT_NEXT - 4'h1;
                end
            end
            ST_STOP: begin
                if (anyStopRelease) begin
                    state_nxt = ST_STAB;
                    stabCnt_nxt = stabLoad(stabSel);
                    if (resetRequest) begin
                        exitKind_nxt = EXIT_RESET;
                    end else if (irqRelease) begin
                        exitKind_nxt = irqService ? EXIT_SERVICE : EXIT_NEXT;
                    end else begin
                        exitKind_nxt = EXIT_NEXT;
                    end
                end
            end
            ST_STAB: begin
                if (stabCnt_r == '0) begin
                    state_nxt = ST_WAKE;
                    wakeCnt_nxt = 4'h0;
                end else begin
                    stabCnt_nxt = stabCnt_r - STAB_CNT_W'(1);
                end
            end
            ST_WAKE: begin
                if (wakeCnt_r == 4'h0) begin
                    state_nxt = ST_RUN;
                end else begin
                    wakeCnt_nxt = wakeCnt_r - 4'h1;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ST_RUN;
            exitKind_r <= EXIT_NEXT;
            stabCnt_r <= '0;
            wakeCnt_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            exitKind_r <= exitKind_nxt;
            stabCnt_r <= stabCnt_nxt;
            wakeCnt_r <= wakeCnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    logic inStopNxt;
    logic standbyNxt;
    logic wakeDone;
    logic [7:0] adLatch_r, adLatch_nxt;
    logic [15:0] addrHold_r, addrHold_nxt;
    logic cpuClockEnable_nxt, mainOscEnable_nxt, resumeNext_nxt;
    logic startService_nxt, startReset_nxt, standbyHalt_nxt, standbyStop_nxt;
    logic crystalPullUp_nxt, portLatchHold_nxt, timer16RunEn_nxt;
    logic timer12RunEn_nxt, timer56RunEn_nxt, watchTimerRunEn_nxt;
    logic realTimePortRunEn_nxt, serialRunEn_nxt;
    logic [7:0] muxed_addr_data_lines_o_nxt;
    logic muxed_addr_data_lines_oe_nxt, addr_latch_strobe_nxt;
    logic readStrobe_nxt, writeStrobe_nxt, waitPinOe_nxt;
    logic [15:0] high_addr_lines_nxt;

    always_comb begin
        inStopNxt = (state_nxt == ST_STOP);
        standbyNxt = (state_nxt != ST_RUN);
        wakeDone = (state_r == ST_WAKE) && (wakeCnt_r == 4'h0);
        cpuClockEnable_nxt = !standbyNxt;
        mainOscEnable_nxt = !inStopNxt;
        resumeNext_nxt = wakeDone && exitKind_r == EXIT_NEXT;
        startService_nxt = wakeDone && exitKind_r == EXIT_SERVICE;
        startReset_nxt = wakeDone && exitKind_r == EXIT_RESET;
        standbyHalt_nxt = standbyNxt && !inStopNxt;
        standbyStop_nxt = inStopNxt;
        crystalPullUp_nxt = inStopNxt;
        portLatchHold_nxt = standbyNxt;
        timer16RunEn_nxt = !inStopNxt || (timer0OnWatchOutput &&
            watchTimerOnSubsystemClock && subsystemClockPresent);
        timer12RunEn_nxt = !inStopNxt || timer1ExtClockSel || timer2ExtClockSel;
        timer56RunEn_nxt = !inStopNxt || timer5ExtClockSel || timer6ExtClockSel;
        watchTimerRunEn_nxt = !inStopNxt ||
            (subsystemClockPresent && watchTimerOnSubsystemClock);
        realTimePortRunEn_nxt = !inStopNxt || realTimeExtTrigger ||
            timer1ExtClockSel || timer2ExtClockSel;
        serialRunEn_nxt = !inStopNxt || (serialExtClock && !serialAutoOrUart);
        // last run values are kept so the parked lines show the pre-entry state
        adLatch_nxt = standbyNxt ? adLatch_r : busAddrDataOut;
        addrHold_nxt = standbyNxt ? addrHold_r : busAddrIn;
        // bus lines park while in standby: address/data and wait float,
        // high address holds, strobe low, read and write inactive high
        muxed_addr_data_lines_o_nxt = standbyNxt ? adLatch_r : busAddrDataOut;
        muxed_addr_data_lines_oe_nxt = !standbyNxt;
        high_addr_lines_nxt = standbyNxt ? addrHold_r : busAddrIn;
        addr_latch_strobe_nxt = standbyNxt ? 1'b0 : busAddrStrobeIn;
        readStrobe_nxt = standbyNxt ? 1'b1 : busReadIn;
        writeStrobe_nxt = standbyNxt ? 1'b1 : busWriteIn;
        waitPinOe_nxt = standbyNxt ? 1'b0 : busWaitOe;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cpuClockEnable <= 1'b1;
            mainOscEnable <= 1'b1;
            resumeNext <= 1'b0;
            startService <= 1'b0;
            startReset <= 1'b0;
            standbyHalt <= 1'b0;
            standbyStop <= 1'b0;
            crystalPullUp <= 1'b0;
            portLatchHold <= 1'b0;
            timer16RunEn <= 1'b1;
            timer12RunEn <= 1'b1;
            timer56RunEn <= 1'b1;
            watchTimerRunEn <= 1'b1;
            realTimePortRunEn <= 1'b1;
            serialRunEn <= 1'b1;
            muxed_addr_data_lines_o <= 8'h00;
            muxed_addr_data_lines_oe <= 1'b0;
            high_addr_lines <= 16'h0000;
            addr_latch_strobe <= 1'b0;
            readStrobe <= 1'b1;
            writeStrobe <= 1'b1;
            waitPinOe <= 1'b0;
            adLatch_r <= 8'h00;
            addrHold_r <= 16'h0000;
        end else begin
            cpuClockEnable <= cpuClockEnable_nxt;
            mainOscEnable <= mainOscEnable_nxt;
            resumeNext <= resumeNext_nxt;
            startService <= startService_nxt;
            startReset <= startReset_nxt;
            standbyHalt <= standbyHalt_nxt;
            standbyStop <= standbyStop_nxt;
            crystalPullUp <= crystalPullUp_nxt;
            portLatchHold <= portLatchHold_nxt;
            timer16RunEn <= timer16RunEn_nxt;
            timer12RunEn <= timer12RunEn_nxt;
            timer56RunEn <= timer56RunEn_nxt;
            watchTimerRunEn <= watchTimerRunEn_nxt;
            realTimePortRunEn <= realTimePortRunEn_nxt;
            serialRunEn <= serialRunEn_nxt;
            muxed_addr_data_lines_o <= muxed_addr_data_lines_o_nxt;
            muxed_addr_data_lines_oe <= muxed_addr_data_lines_oe_nxt;
            high_addr_lines <= high_addr_lines_nxt;
            addr_latch_strobe <= addr_latch_strobe_nxt;
            readStrobe <= readStrobe_nxt;
            writeStrobe <= writeStrobe_nxt;
            waitPinOe <= waitPinOe_nxt;
            adLatch_r <= adLatch_nxt;
            addrHold_r <= addrHold_nxt;
        end
    end
endmodule // standby_mode_controller

// [rtl/standby_pkg.sv]
// constants and types shared by the standby mode controller
package standby_pkg;
    // wake-up waits in clocks after a halt release
    localparam logic [3:0] WAIT_VECTORED = 4'h8;
    localparam logic [3:0] WAIT_NEXT = 4'h2;
    // stabilization select codes map to 2^(13+sel) oscillator cycles, sel 0..4
    localparam logic [2:0] STAB_SEL_RESET = 3'h4;
    localparam int STAB_BASE_LOG2 = 13;
    localparam logic [2:0] STAB_SEL_MAX = 3'h4;
    localparam int STAB_CNT_W = 18;

    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_HALT = 5'b00010,
        ST_STOP = 5'b00100,
        ST_STAB = 5'b01000,
        ST_WAKE = 5'b10000
    } standby_state_e;

    typedef enum logic [1:0] {
        EXIT_NEXT = 2'h0,
        EXIT_SERVICE = 2'h1,
        EXIT_RESET = 2'h2
    } exit_kind_e;
endpackage

// [test/cpu_model.sv]
// cpu core model: issues halt and stop, drives moving bus values
module cpu_model (
    input wire logic clk, srst, cpuClockEnable,
    input wire logic [1:0] cmd,
    output logic haltExec, stopExec, busAddrStrobeIn, busReadIn, busWriteIn, busWaitOe,
    output logic [7:0] busAddrDataOut,
    output logic [15:0] busAddrIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic haltExec_nxt, stopExec_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    always_comb begin
        // instructions only issue while the core is clocked
        haltExec_nxt = cmd == 2'h1 && cpuClockEnable;
        stopExec_nxt = cmd == 2'h2 && cpuClockEnable;
        cnt_nxt = cnt_r + 8'h1;
    end
    always_ff @(posedge clk) begin
        haltExec <= !srst && haltExec_nxt;
        stopExec <= !srst && stopExec_nxt;
        cnt_r <= srst ? 8'h00 : cnt_nxt;
    end
    // values keep moving so a parked or held output cannot pass by accident
    assign busAddrDataOut = cnt_r;
    assign busAddrIn = {~cnt_r, cnt_r};
    assign {busAddrStrobeIn, busReadIn, busWriteIn, busWaitOe} =
        {cnt_r[0], cnt_r[1], ~cnt_r[1], 1'b1};
endmodule // cpu_model

// [test/standby_checks_assertions.sv]
// concurrent checks on the standby controller ports
module standby_checks (
    input wire logic clk, srst, haltExec, stopExec, cpuOnSubsystemClock,
    input wire logic subsystemClockPresent, watchTimerOnSubsystemClock, timer0OnWatchOutput,
    input wire logic cpuClockEnable, mainOscEnable, resumeNext, startService, startReset,
    input wire logic standbyHalt, standbyStop, crystalPullUp, portLatchHold,
    input wire logic timer16RunEn, watchTimerRunEn, muxed_addr_data_lines_oe,
    input wire logic addr_latch_strobe, readStrobe, writeStrobe, waitPinOe,
    input wire logic [7:0] busAddrDataOut, muxed_addr_data_lines_o,
    input wire logic [15:0] busAddrIn, high_addr_lines
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_HALT_ENTRY:
    assert property (haltExec && !stopExec && cpuClockEnable && !standbyHalt && !standbyStop
        |=> standbyHalt && !cpuClockEnable) else $error("halt not entered");
    AST_STOP_SUBCLK:
    assert property (stopExec && cpuOnSubsystemClock |=> !standbyStop) else $error("stop taken");
    AST_STOP_CAUSE:
    assert property ($rose(standbyStop) |-> $past(stopExec)) else $error("stop without exec");
    AST_PULLUP:
    assert property (crystalPullUp == standbyStop) else $error("pull-up wrong");
    AST_STOP_OSC:
    assert property (standbyStop |-> !mainOscEnable && !cpuClockEnable && portLatchHold)
        else $error("stop clocks wrong");
    AST_TIMER16:
    assert property (standbyStop |-> timer16RunEn == (timer0OnWatchOutput
        && watchTimerOnSubsystemClock && subsystemClockPresent)) else $error("timer16 run");
    AST_WATCH:
    assert property (standbyStop |-> watchTimerRunEn == (subsystemClockPresent
        && watchTimerOnSubsystemClock)) else $error("watch timer run");
    AST_PARK:
    assert property (standbyStop |-> !muxed_addr_data_lines_oe && !waitPinOe
        && !addr_latch_strobe && readStrobe && writeStrobe) else $error("bus not parked");
    AST_PULSE_ONE:
    assert property ($onehot0({resumeNext, startService, startReset})) else $error("two exits");
    AST_PULSE_RUN:
    assert property (resumeNext || startService |-> cpuClockEnable && !standbyHalt
        ##1 !(resumeNext || startService)) else $error("exit pulse wrong");
    AST_BUS_PASS:
    assert property (!portLatchHold && !$past(srst) |-> muxed_addr_data_lines_oe
        && muxed_addr_data_lines_o == $past(busAddrDataOut)
        && high_addr_lines == $past(busAddrIn)) else $error("bus not passed through");
endmodule // standby_checks

bind standby_mode_controller standby_checks standby_checks_i (.*);

// [test/tb_top.sv]
// self-checking bench for the standby mode controller
module tb_top import standby_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STB = 2;
    logic clk = 1'b0, srst = 1'b1, cpuOnSubsystemClock = 1'b0;
    logic [1:0] cmd = 2'h0;
    logic [2:0] stabilization_time_select = 3'h0;
    logic [3:0] src = 4'h0;
    logic [4:0] flg = 5'h00;
    logic [9:0] cfg = 10'h000;
    int checks = 0, mismatches = 0, n;
    wire logic resetRequest, nmiRequest, maskIrqRequest, testInput, testMaskFlag;
    wire logic interrupt_mask_flag, priority_select_flag, interrupt_acknowledge_enable;
    wire logic in_service_priority_flag, subsystemClockPresent, watchTimerOnSubsystemClock;
    wire logic timer0OnWatchOutput, timer1ExtClockSel, timer2ExtClockSel, timer5ExtClockSel;
    wire logic timer6ExtClockSel, realTimeExtTrigger, serialExtClock, serialAutoOrUart;
    logic haltExec, stopExec, busAddrStrobeIn, busReadIn, busWriteIn, busWaitOe;
    logic cpuClockEnable, mainOscEnable, resumeNext, startService, startReset, standbyHalt;
    logic standbyStop, crystalPullUp, portLatchHold, timer16RunEn, timer12RunEn, timer56RunEn;
    logic watchTimerRunEn, realTimePortRunEn, serialRunEn, muxed_addr_data_lines_oe;
    logic addr_latch_strobe, readStrobe, writeStrobe, waitPinOe;
    logic [7:0] busAddrDataOut, muxed_addr_data_lines_o;
    logic [15:0] busAddrIn, high_addr_lines;
    assign {resetRequest, nmiRequest, maskIrqRequest, testInput} = src;
    assign {testMaskFlag, interrupt_mask_flag, priority_select_flag} = flg[4:2];
    assign {interrupt_acknowledge_enable, in_service_priority_flag} = flg[1:0];
    assign {subsystemClockPresent, watchTimerOnSubsystemClock, timer0OnWatchOutput} = cfg[9:7];
    assign {timer1ExtClockSel, timer2ExtClockSel, timer5ExtClockSel, timer6ExtClockSel} = cfg[6:3];
    assign {realTimeExtTrigger, serialExtClock, serialAutoOrUart} = cfg[2:0];
    standby_mode_controller #(.STAB_BASE(STB)) standby_mode_controller_i (.*);
    cpu_model cpu_model_i (.*);
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic waitPulse();
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while ({resumeNext, startService, startReset} === 3'h0 && n < 900);
    endtask
    task automatic issue(input logic [1:0] c);
        @(posedge clk) cmd <= c;
        @(posedge clk) cmd <= 2'h0;
        @(posedge clk) #1;
    endtask
    function automatic logic [5:0] runExp(input logic [9:0] c);
        return {c[9] & c[8] & c[7], c[6] | c[5], c[4] | c[3], c[9] & c[8],
            c[2] | c[6] | c[5], c[1] & ~c[0]};
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic haltCase(input logic [4:0] f, input logic [3:0] s, input logic [2:0] k, int w);
        @(posedge clk) flg <= f;
        issue(2'h1);
        chk("haltEntry", {standbyHalt, cpuClockEnable}, 8'h02);
        @(posedge clk) src <= s;
        if (k == 3'h0) begin
            repeat (20) @(posedge clk);
            #1 chk("haltHold", {standbyHalt, startService, resumeNext}, 8'h04);
            @(posedge clk) src <= 4'h8;
            k = 3'h4;
            w = 1;
        end
        waitPulse();
        chk("haltKind", {startReset, startService, resumeNext},
            k);
        chk("haltWait", n >= w + 1 && n <= w + 2, 8'h01);
        @(posedge clk) src <= 4'h0;
    endtask
    task automatic stopCase(input logic [9:0] c, input logic [2:0] sel, input logic [3:0] s,
        input logic [4:0] f, input logic [2:0] k);
        logic [15:0] a;
        int w;
        w = 1 << (STB + (sel > 3'h4 ? 4 : sel));
        @(posedge clk);
        cfg <= c;
        flg <= f;
        stabilization_time_select <= sel;
        issue(2'h2);
        chk("stopEntry", {standbyStop, crystalPullUp, mainOscEnable, portLatchHold},
            8'h0d);
        chk("stopRun", {timer16RunEn, timer12RunEn, timer56RunEn, watchTimerRunEn,
            realTimePortRunEn, serialRunEn},
            runExp(c));
        a = high_addr_lines;
        @(posedge clk) src <= 4'h4;
        repeat (4) @(posedge clk);
        #1 chk("stopNmi", {standbyStop, high_addr_lines === a}, 8'h03);
        @(posedge clk) src <= s;
        waitPulse();
        chk("stopKind", {startReset, startService, resumeNext}, k);
        chk("stopWait", n >= w && n <= w + 8, 8'h01);
        @(posedge clk) src <= 4'h0;
    endtask
    task automatic pendStop();
        @(posedge clk);
        flg <= 5'h02;
        src <= 4'h2;
        issue(2'h2);
        chk("stopPend", {standbyStop, standbyHalt, cpuClockEnable}, 8'h02);
        waitPulse();
        chk("pendKind", {startReset, startService, resumeNext}, 8'h02);
        @(posedge clk) src <= 4'h0;
    endtask
    task automatic subClk();
        @(posedge clk) cpuOnSubsystemClock <= 1'b1;
        issue(2'h2);
        chk("stopSub", {standbyStop, cpuClockEnable}, 8'h01);
        haltCase(5'h00, 4'h1, 3'h1, WAIT_NEXT);
        @(posedge clk) cpuOnSubsystemClock <= 1'b0;
    endtask
    initial forever #12.5 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1 chk("reset", {cpuClockEnable, mainOscEnable, standbyHalt, standbyStop,
            crystalPullUp, readStrobe}, 8'h31);
        haltCase(5'h02, 4'h2, 3'h2, WAIT_VECTORED);
        haltCase(5'h00, 4'h2, 3'h1, WAIT_NEXT);
        haltCase(5'h05, 4'h2, 3'h1, WAIT_NEXT);
        haltCase(5'h06, 4'h2, 3'h1, WAIT_NEXT);
        haltCase(5'h07, 4'h2, 3'h2, WAIT_VECTORED);
        haltCase(5'h0a, 4'h2, 3'h0, 0);
        haltCase(5'h00, 4'h4, 3'h2, WAIT_VECTORED);
        haltCase(5'h00, 4'h1, 3'h1, WAIT_NEXT);
        haltCase(5'h10, 4'h1, 3'h0, 0);
        haltCase(5'h00, 4'h8, 3'h4, 1);
        subClk();
        pendStop();
        stopCase(10'h3e2, 3'h1, 4'h1, 5'h00, 3'h1);
        stopCase(10'h09d, 3'h2, 4'h2, 5'h02, 3'h2);
        stopCase(10'h020, 3'h6, 4'h8, 5'h00, 3'h4);
        wrap_up();
    end
endmodule // tb_top
